// ---- common/rsu_defines.svh ----
// Purpose : Constants of the right-shift unit
// Assumes : 32-bit R-type instruction words
// Notes   : Field positions and opcode values
`ifndef RSU_DEFINES_SVH
`define RSU_DEFINES_SVH
`define RSU_OP_LSB        0
`define RSU_OP_MSB        5
`define RSU_CNT_LSB       6
`define RSU_CNT_MSB       10
`define RSU_OPX_LSB       11
`define RSU_OPX_MSB       16
`define RSU_C_LSB         17
`define RSU_C_MSB         21
`define RSU_B_LSB         22
`define RSU_B_MSB         26
`define RSU_A_LSB         27
`define RSU_A_MSB         31
`define RSU_OP_RTYPE      6'h3A
`define RSU_OPX_SRA_REG   6'h3B
`define RSU_OPX_SRA_IMM   6'h3A
`define RSU_OPX_SRL_REG   6'h1B
`define RSU_RESULT_RST    32'h0000_0000
`define RSU_DEST_RST      5'h00
`define RSU_CHK_AMT_RST   5'h00
`define RSU_CHK_WORD_RST  32'h0000_0000
`endif

// ---- common/rsu_pkg.sv ----
// Purpose : Types of the right-shift unit
// Assumes : Nothing beyond the defines header
// Notes   : Holds types only
package rsu_pkg;
   typedef enum logic [1:0] {
      RSU_NONE,
      RSU_SRA_REG,
      RSU_SRA_IMM,
      RSU_SRL_REG
   } rsu_op_e;
   typedef logic [31:0] rsu_word_t;
   typedef logic [4:0]  rsu_amt_t;
endpackage

// ---- hdl/rsu_right_shift_unit.sv ----
// Purpose : Right-shift group of the integer datapath
// Assumes : Operands arrive with the instruction word in the same cycle
// Notes   : Result registered one cycle after a valid request
`timescale 1ns/100ps
`include "rsu_defines.svh"

// Function
// RULE_01: SRA by operand B bits 4..0, sign fill
// RULE_02: SRA by immediate count, sign fill
// RULE_03: Immediate count is 5-bit unsigned
// RULE_04: SRL by operand B bits 4..0, zero fill
// RULE_05: Logical shift treats operand A unsigned
// RULE_06: Decode R-type opcode 0x3A with extensions
module rsu_right_shift_unit (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   input  wire logic [31:0] source_operand_a,
   input  wire logic [31:0] source_operand_b,
   output logic      [31:0] destination_operand,
   output logic      [4:0]  dest_index,
   output logic             result_valid,
   output logic             illegal_op
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic rsu_pkg::rsu_op_e decode_op(input logic [31:0] w);
      logic [5:0] op;
      logic [5:0] opx;
      logic [4:0] cnt;
      logic [4:0] bidx;
      op   = w[`RSU_OP_MSB:`RSU_OP_LSB];
      opx  = w[`RSU_OPX_MSB:`RSU_OPX_LSB];
      cnt  = w[`RSU_CNT_MSB:`RSU_CNT_LSB];
      bidx = w[`RSU_B_MSB:`RSU_B_LSB];
      decode_op = rsu_pkg::RSU_NONE;
      if (op == `RSU_OP_RTYPE) begin
         if (opx == `RSU_OPX_SRA_REG && cnt == 5'h00) begin
            decode_op = rsu_pkg::RSU_SRA_REG;
         end else if (opx == `RSU_OPX_SRA_IMM && bidx == 5'h00) begin
            decode_op = rsu_pkg::RSU_SRA_IMM;
         end else if (opx == `RSU_OPX_SRL_REG && cnt == 5'h00) begin
            decode_op = rsu_pkg::RSU_SRL_REG;
         end
      end
   endfunction

   rsu_pkg::rsu_op_e   op_sel;
   rsu_pkg::rsu_amt_t  shift_count_field;
   rsu_pkg::rsu_amt_t  amount;
   logic               arith;
   rsu_pkg::rsu_word_t shifted;

   assign op_sel            = decode_op(instr_word);          // see RULE_06
   assign shift_count_field = instr_word[`RSU_CNT_MSB:`RSU_CNT_LSB]; // see RULE_03

   always_comb begin
      amount = source_operand_b[4:0];                          // see RULE_01
      arith  = 1'b1;
      case (op_sel)
         rsu_pkg::RSU_SRA_REG: begin
            amount = source_operand_b[4:0];                    // see RULE_01
            arith  = 1'b1;
         end
         rsu_pkg::RSU_SRA_IMM: begin
            amount = shift_count_field;                        // see RULE_02
            arith  = 1'b1;
         end
         rsu_pkg::RSU_SRL_REG: begin
            amount = source_operand_b[4:0];                    // see RULE_04
            arith  = 1'b0;                                     // see RULE_05
         end
         default: begin
            amount = 5'h00;
            arith  = 1'b0;
         end
      endcase
   end

   rsu_shifter u_shifter (
      .value  (source_operand_a),
      .amount (amount),
      .arith  (arith),
      .result (shifted)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Result registers

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         result_valid <= 1'b0;
         illegal_op   <= 1'b0;
      end else begin
         result_valid <= instr_valid && (op_sel != rsu_pkg::RSU_NONE);
         illegal_op   <= instr_valid && (op_sel == rsu_pkg::RSU_NONE);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         destination_operand <= `RSU_RESULT_RST;
         dest_index          <= `RSU_DEST_RST;
      end else if (instr_valid && op_sel != rsu_pkg::RSU_NONE) begin
         destination_operand <= shifted;                       // see RULE_01
         dest_index          <= instr_word[`RSU_C_MSB:`RSU_C_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Request as it stood at the taking edge, for comparison one cycle later
   rsu_pkg::rsu_word_t chk_a_q;
   rsu_pkg::rsu_amt_t  chk_b_q;
   rsu_pkg::rsu_word_t chk_w_q;
   rsu_pkg::rsu_word_t exp_sra_reg;
   rsu_pkg::rsu_word_t exp_sra_imm;
   rsu_pkg::rsu_word_t exp_srl_reg;
   logic               req_sra_reg;
   logic               req_sra_imm;
   logic               req_srl_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chk_a_q <= `RSU_CHK_WORD_RST;
      end else begin
         chk_a_q <= source_operand_a;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chk_b_q <= `RSU_CHK_AMT_RST;
      end else begin
         chk_b_q <= source_operand_b[4:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chk_w_q <= `RSU_CHK_WORD_RST;
      end else begin
         chk_w_q <= instr_word;
      end
   end

   // Own assignments keep operand A signed; inside a compare with an unsigned port it would not be
   assign exp_sra_reg = $signed(chk_a_q) >>> chk_b_q;
   assign exp_sra_imm = $signed(chk_a_q) >>> chk_w_q[`RSU_CNT_MSB:`RSU_CNT_LSB];
   assign exp_srl_reg = chk_a_q >> chk_b_q;

   // Raw field matches, kept apart from the decode function so a decode fault shows
   assign req_sra_reg = instr_valid && instr_word[`RSU_OP_MSB:`RSU_OP_LSB] == `RSU_OP_RTYPE
                        && instr_word[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_SRA_REG
                        && instr_word[`RSU_CNT_MSB:`RSU_CNT_LSB] == 5'h00;
   assign req_sra_imm = instr_valid && instr_word[`RSU_OP_MSB:`RSU_OP_LSB] == `RSU_OP_RTYPE
                        && instr_word[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_SRA_IMM
                        && instr_word[`RSU_B_MSB:`RSU_B_LSB] == 5'h00;
   assign req_srl_reg = instr_valid && instr_word[`RSU_OP_MSB:`RSU_OP_LSB] == `RSU_OP_RTYPE
                        && instr_word[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_SRL_REG
                        && instr_word[`RSU_CNT_MSB:`RSU_CNT_LSB] == 5'h00;

   sra_reg_result_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_01
      req_sra_reg |=> result_valid && destination_operand == exp_sra_reg)
      else $error("register arithmetic shift result wrong");

   sra_imm_result_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_02
      req_sra_imm |=> result_valid && destination_operand == exp_sra_imm)
      else $error("immediate arithmetic shift result wrong");

   imm_count_range_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_03
      req_sra_imm && instr_word[`RSU_CNT_MSB:`RSU_CNT_LSB] == 5'h1F |=>
         destination_operand == {32{chk_a_q[31]}})
      else $error("immediate count of 31 not honoured");

   srl_reg_result_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_04
      req_srl_reg |=> result_valid && destination_operand == exp_srl_reg)
      else $error("logical shift result wrong");

   srl_zero_fill_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_05
      req_srl_reg && source_operand_b[4:0] != 5'h00 |=>
         destination_operand[31] == 1'b0)
      else $error("logical shift propagated sign");

   decode_valid_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      instr_valid && instr_word[`RSU_OP_MSB:`RSU_OP_LSB] != `RSU_OP_RTYPE |=> !result_valid && illegal_op)
      else $error("foreign opcode accepted");

   dest_index_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      result_valid |-> dest_index == chk_w_q[`RSU_C_MSB:`RSU_C_LSB])
      else $error("destination index wrong");

   idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !instr_valid |=> !result_valid && $stable(destination_operand))
      else $error("result changed without request");

   refused_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      instr_valid && op_sel == rsu_pkg::RSU_NONE |=>
         illegal_op && !result_valid && $stable(destination_operand) && $stable(dest_index))
      else $error("refused word changed the result");

   imm_b_field_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      instr_valid && instr_word[`RSU_OP_MSB:`RSU_OP_LSB] == `RSU_OP_RTYPE
         && instr_word[`RSU_OPX_MSB:`RSU_OPX_LSB] == `RSU_OPX_SRA_IMM
         && instr_word[`RSU_B_MSB:`RSU_B_LSB] != 5'h00 |=> illegal_op && !result_valid)
      else $error("immediate form with nonzero B field accepted");

   pulse_exclusive_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      !(result_valid && illegal_op))
      else $error("result and refusal flagged together");

   idle_no_refusal_a: assert property (@(posedge mclk) disable iff (!rst_b) // see RULE_06
      !instr_valid |=> !illegal_op)
      else $error("refusal flagged without request");

   sra_reg_c: cover property (@(posedge mclk) disable iff (!rst_b)
      instr_valid && op_sel == rsu_pkg::RSU_SRA_REG && source_operand_a[31]);
   sra_imm_c: cover property (@(posedge mclk) disable iff (!rst_b)
      instr_valid && op_sel == rsu_pkg::RSU_SRA_IMM);
   srl_reg_c: cover property (@(posedge mclk) disable iff (!rst_b)
      instr_valid && op_sel == rsu_pkg::RSU_SRL_REG && source_operand_b[31:5] != 27'h0);
   illegal_c: cover property (@(posedge mclk) disable iff (!rst_b)
      instr_valid && op_sel == rsu_pkg::RSU_NONE);
   back_to_back_c: cover property (@(posedge mclk) disable iff (!rst_b)
      instr_valid && result_valid);

endmodule // rsu_right_shift_unit

// ---- hdl/rsu_shifter.sv ----
// Purpose : Combinational 32-bit right shifter
// Assumes : Amount already reduced to five bits
// Notes   : Fill bit is sign or zero
`timescale 1ns/100ps
module rsu_shifter (
   input  wire logic [31:0] value,
   input  wire logic [4:0]  amount,
   input  wire logic        arith,
   output logic      [31:0] result
);
   logic fill_bit;
   assign fill_bit = arith & value[31];
   always_comb begin
      result = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         if (i + int'(amount) < 32) begin
            result[i] = value[i + int'(amount)];
         end else begin
            result[i] = fill_bit;
         end
      end
   end
endmodule // rsu_shifter

// ---- tb/right_shift_unit_tb.sv ----
// Purpose : Self-checking bench of the right-shift unit
// Assumes : Result one cycle after the taking edge
// Notes   : Register file model supplies operands
`timescale 1ns/100ps
`include "rsu_defines.svh"
module right_shift_unit_tb;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        instr_valid = 1'b0;
   logic [31:0] instr_word = 32'h0000_0000;
   logic        wr_en = 1'b0;
   logic [4:0]  wr_idx = 5'h00;
   logic [31:0] wr_data = 32'h0000_0000;
   logic [31:0] source_operand_a, source_operand_b, destination_operand;
   logic [4:0]  dest_index;
   logic        result_valid, illegal_op;
   int          bad_count = 0;
   int          check_count = 0;
   logic [31:0] vals [2] = '{32'h8000_0010, 32'h7000_00F1};
   always #25 mclk = ~mclk;
   rsu_regfile_model rf_u (.mclk(mclk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
      .instr_word(instr_word), .source_operand_a(source_operand_a), .source_operand_b(source_operand_b));
   rsu_right_shift_unit dut_u (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
      .source_operand_a(source_operand_a), .source_operand_b(source_operand_b),
      .destination_operand(destination_operand), .dest_index(dest_index),
      .result_valid(result_valid), .illegal_op(illegal_op));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [4:0] idx, input logic [31:0] val);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_idx <= idx;
      wr_data <= val;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   function automatic logic [31:0] w(input logic [4:0] a, b, c, input logic [5:0] opx, input logic [4:0] n);
      w = {a, b, c, opx, n, 6'h3A};
   endfunction
   // Issues one word, then judges the pulse and the held outputs
   task automatic run(input logic [31:0] word, input logic [31:0] exp, input logic bad);
      logic [31:0] prev_d;
      logic [4:0]  prev_i;
      prev_d = destination_operand;
      prev_i = dest_index;
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= word;
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(negedge mclk);
      chk({31'h0, result_valid}, {31'h0, ~bad});
      chk({31'h0, illegal_op}, {31'h0, bad});
      chk(destination_operand, bad ? prev_d : exp);
      chk({27'h0, dest_index}, {27'h0, bad ? prev_i : word[21:17]});
      @(negedge mclk);
      chk({30'h0, result_valid, illegal_op}, 32'h0000_0000);
   endtask
   // Reset held for three edges; outputs cleared during it and at the first edge after
   task automatic scen_reset_start;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk(destination_operand, `RSU_RESULT_RST);
      chk({27'h0, dest_index}, {27'h0, `RSU_DEST_RST});
      chk({30'h0, result_valid, illegal_op}, 32'h0000_0000);
      @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk({30'h0, result_valid, illegal_op}, 32'h0000_0000);
      chk(destination_operand, `RSU_RESULT_RST);
   endtask
   task automatic scen_load;
      put(5'h01, vals[0]);
      put(5'h02, vals[1]);
   endtask
   task automatic scen_shift_sweep;
      for (int n = 0; n < 32; n++) begin
         put(5'h03, {27'h7FF_FFFF, n[4:0]});
         for (int s = 0; s < 2; s++) begin
            run(w(5'(s + 1), 5'h03, 5'h05, 6'h3B, 5'h00), $signed(vals[s]) >>> n, 1'b0);
            run(w(5'(s + 1), 5'h00, 5'h06, 6'h3A, n[4:0]), $signed(vals[s]) >>> n, 1'b0);
            run(w(5'(s + 1), 5'h03, 5'h07, 6'h1B, 5'h00), vals[s] >> n, 1'b0);
         end
      end
   endtask
   task automatic scen_refused;
      run(w(5'h01, 5'h03, 5'h08, 6'h3B, 5'h01), 32'h0000_0000, 1'b1);
      run(w(5'h01, 5'h03, 5'h09, 6'h3A, 5'h02), 32'h0000_0000, 1'b1);
      run(w(5'h01, 5'h03, 5'h0A, 6'h1B, 5'h04), 32'h0000_0000, 1'b1);
      run(w(5'h01, 5'h03, 5'h0B, 6'h1A, 5'h00), 32'h0000_0000, 1'b1);
      run(w(5'h01, 5'h03, 5'h0C, 6'h3B, 5'h00) ^ 32'h0000_0001, 32'h0000_0000, 1'b1);
   endtask
   // Two accepted words on consecutive edges, each answered in its own cycle
   task automatic scen_back_to_back;
      put(5'h03, 32'h0000_0021);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= w(5'h01, 5'h03, 5'h0D, 6'h3B, 5'h00);
      @(posedge mclk);
      instr_word <= w(5'h02, 5'h00, 5'h0E, 6'h3A, 5'h04);
      @(negedge mclk);
      chk(destination_operand, 32'hC000_0008);
      chk({27'h0, dest_index}, 32'h0000_000D);
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(negedge mclk);
      chk(destination_operand, 32'h0700_000F);
      chk({27'h0, dest_index}, 32'h0000_000E);
      chk({30'h0, result_valid, illegal_op}, 32'h0000_0002);
      @(negedge mclk);
      chk({30'h0, result_valid, illegal_op}, 32'h0000_0000);
   endtask
   // Reset in mid-run clears the held result; the first word after release is served
   task automatic scen_mid_reset;
      @(posedge mclk);
      rst_b <= 1'b0;
      @(negedge mclk);
      chk(destination_operand, `RSU_RESULT_RST);
      chk({27'h0, dest_index}, {27'h0, `RSU_DEST_RST});
      @(posedge mclk);
      rst_b <= 1'b1;
      run(w(5'h01, 5'h00, 5'h0F, 6'h3A, 5'h01), 32'hC000_0008, 1'b0);
   endtask
   task automatic end_sim;
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      scen_reset_start();
      scen_load();
      scen_shift_sweep();
      scen_refused();
      scen_back_to_back();
      scen_mid_reset();
      end_sim();
   end
endmodule // right_shift_unit_tb

// ---- tb/rsu_regfile_model.sv ----
// Purpose : Register file feeding the shift unit
// Assumes : Operand indices come from the instruction word
// Notes   : Reads are combinational, writes on mclk
`timescale 1ns/100ps
module rsu_regfile_model (
   input  wire logic        mclk,
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_idx,
   input  wire logic [31:0] wr_data,
   input  wire logic [31:0] instr_word,
   output logic      [31:0] source_operand_a,
   output logic      [31:0] source_operand_b
);
   logic [31:0] regs_q [32];
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         regs_q[wr_idx] <= wr_data;
      end
   end
   assign source_operand_a = regs_q[instr_word[31:27]];
   assign source_operand_b = regs_q[instr_word[26:22]];
endmodule // rsu_regfile_model
